// >>> hw/pin_ctrl_cfg.svh
`ifndef PIN_CTRL_CFG_SVH
`define PIN_CTRL_CFG_SVH

// Register byte offsets on the APB.
`define OFF_CONTROL   12'h000
`define OFF_STATUS    12'h004
`define OFF_HIGH_PORT 12'h008
`define OFF_MUX_PORT  12'h00C
`define OFF_MUX_DIR   12'h010
`define OFF_BUSREQ    12'h014

// Control register fields.
`define CTL_EDGE_BIT   0
`define CTL_XMASK_BIT  1
`define CTL_IMASK_BIT  2
`define CTL_IRV_BIT    3
`define CTL_ACK_BIT    4
`define CTL_XACK_BIT   5
`define CTL_OSTB_BIT   6
`define CTL_FETCH_BIT  7

// Bus request register fields.
`define BRQ_ADDR_LSB   0
`define BRQ_DATA_LSB   16
`define BRQ_WRITE_BIT  24
`define BRQ_INT_BIT    25

// Reset values of the control bits.
`define RST_EDGE_SEL   1'b0
`define RST_XMASK      1'b1
`define RST_IMASK      1'b1

// Cycles after reset release before the mode pins are trusted.
`define MODE_SETTLE    3'h4

// E clock is one quarter of the system clock.
`define ECLK_DIV       2'h3

`endif

// >>> hw/pin_ctrl_pkg.sv
package pin_ctrl_pkg;
    typedef enum logic [1:0] {
        MODE_BOOT   = 2'b00,
        MODE_SINGLE = 2'b01,
        MODE_TEST   = 2'b10,
        MODE_EXPAND = 2'b11
    } op_mode_t;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_ADDR = 2'b01,
        PH_DATA = 2'b10
    } bus_phase_t;
endpackage

// >>> hw/pin_sync_if.sv
`timescale 1ns/100ps
`default_nettype none
interface pin_sync_if;
    logic [3:0] raw;
    logic [3:0] clean;
    modport owner (output raw, input clean);
    modport sync (input raw, output clean);
endinterface
`default_nettype wire

// >>> hw/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
    // Clock and reset.
    input  wire logic clk_sys,
    input  wire logic rst,
    // Pins in and filtered levels out.
    pin_sync_if.sync  pins
);
    logic [3:0] stage1_ff;
    logic [3:0] stage2_ff;
    logic [3:0] stage3_ff;
    logic [3:0] clean_ff;
    logic [3:0] nxt_clean;

    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_bit
            always_comb begin
                nxt_clean[i] = (stage2_ff[i] == stage3_ff[i]) ? stage3_ff[i] : clean_ff[i];
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or posedge rst) begin
        // Reset values follow each pin's idle level, so no false edge follows reset.
        if (rst) begin
            stage1_ff <= 4'h7;
            stage2_ff <= 4'h7;
            stage3_ff <= 4'h7;
            clean_ff  <= 4'h7;
        end else begin
            stage1_ff <= pins.raw;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
            clean_ff  <= nxt_clean;
        end
    end

    assign pins.clean = clean_ff;
endmodule
`default_nettype wire

// >>> hw/pin_ctrl.sv
// Function
// - Maskable input edge or level, software chosen.
// - Reset forces maskable input to level trigger.
// - Reset sets non-maskable mask flag.
// - Non-maskable request is level sensitive.
// - Held line re-interrupts once mask clears.
// - Mode pins sampled at reset pick mode.
// - Fetch indicator open drain, low on fetch.
// - Single-chip: strobe-A pin is input strobe.
// - Expanded: strobe-A pin drives address strobe.
// - Single-chip: strobe-B pin is output strobe.
// - Expanded: direction low write, high read.
// - Direction stays low across back-to-back writes.
// - Visible internal reads drive muxed port.
// - High port: outputs or high address.
// - Muxed port: bidirectional or address/data.
// - Other ports independent of mode.
// - E clock is quarter rate, high accesses.
// - Expanded: address 15..8 on high port.
// - Expanded: address 7..0 then data at E high.
`timescale 1ns/100ps
`default_nettype none
`include "pin_ctrl_cfg.svh"
module pin_ctrl (
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Interrupt and mode pins.
    input  wire logic        irqPin_n,
    input  wire logic        nonmaskable_request_n,
    input  wire logic        mode_select_a,
    input  wire logic        mode_select_b,
    // Debug and strobes.
    output logic             opcode_fetch_indicator_n,
    output logic             fetchIndOe_n,
    input  wire logic        input_strobe,
    output logic             address_latch_strobe,
    output logic             output_strobe,
    output logic             eClk,
    // Requests toward the core.
    output logic             irqReq,
    output logic             xirqReq,
    // Ports.
    output logic      [7:0]  high_port_pins,
    input  wire logic [7:0]  muxed_port_pins_in,
    output logic      [7:0]  muxed_port_pins_out,
    output logic      [7:0]  muxedPortOe_n
);
    ////////////////////////////////////////////////////////////////////////////
    pin_sync_if syn ();
    assign syn.raw = {input_strobe, mode_select_b, nonmaskable_request_n, irqPin_n};

    pin_sync u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pins    (syn)
    );

    logic irqLvl;
    logic xirqLvl;
    logic strobeLvl;
    assign irqLvl    = syn.clean[0];
    assign xirqLvl   = syn.clean[1];
    assign strobeLvl = syn.clean[3];

    logic [2:0] modeA_ff;
    logic       modeAClean_ff;
    logic       modeALvl;
    // The mode-A pin has no slot in the shared synchroniser, so it has its own four flops.
    assign modeALvl = (modeA_ff[2] == modeA_ff[1]) ? modeA_ff[2] : modeAClean_ff;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            modeA_ff      <= 3'h0;
            modeAClean_ff <= 1'b0;
        end else begin
            modeA_ff      <= {modeA_ff[1:0], mode_select_a};
            modeAClean_ff <= modeALvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State registers.
    logic [1:0]          ediv_ff, nxt_ediv;
    logic                eClk_ff, nxt_eClk;
    logic                latched_ff, nxt_latched;
    logic [2:0]          settleCnt_ff, nxt_settleCnt;
    logic                strobeB_ff, nxt_strobeB;
    pin_ctrl_pkg::op_mode_t mode_ff, nxt_mode;
    logic                edgeSel_ff, nxt_edgeSel;
    logic                xMask_ff, nxt_xMask;
    logic                iMask_ff, nxt_iMask;
    logic                irv_ff, nxt_irv;
    logic                irqPrev_ff, nxt_irqPrev;
    logic                irqPend_ff, nxt_irqPend;
    logic                strPrev_ff, nxt_strPrev;
    logic                strEvt_ff, nxt_strEvt;
    logic [7:0]          hiData_ff, nxt_hiData;
    logic [7:0]          muxData_ff, nxt_muxData;
    logic [7:0]          muxDir_ff, nxt_muxDir;
    logic [7:0]          muxIn_ff, nxt_muxIn;
    logic [25:0]         brq_ff, nxt_brq;
    logic                brqValid_ff, nxt_brqValid;
    logic                fetchReq_ff, nxt_fetchReq;
    pin_ctrl_pkg::bus_phase_t ph_ff, nxt_ph;
    logic                rw_ff, nxt_rw;
    logic                as_ff, nxt_as;
    logic                ostb_ff, nxt_ostb;
    logic                fetch_ff, nxt_fetch;
    logic [7:0]          hiOut_ff, nxt_hiOut;
    logic [7:0]          muxOut_ff, nxt_muxOut;
    logic [7:0]          muxOe_ff, nxt_muxOe;
    logic                irqReq_ff, nxt_irqReq;
    logic                xirqReq_ff, nxt_xirqReq;
    logic [31:0]         prdata_ff, nxt_prdata;
    logic                pready_ff, nxt_pready;
    logic                pslverr_ff, nxt_pslverr;

    logic expanded;
    logic eTick;
    logic wrEn;
    logic rdEn;
    assign expanded = (mode_ff == pin_ctrl_pkg::MODE_EXPAND) ||
                      (mode_ff == pin_ctrl_pkg::MODE_TEST);
    assign eTick = (ediv_ff == `ECLK_DIV);
    assign wrEn  = psel && penable && pwrite && !pready_ff;
    assign rdEn  = psel && penable && !pwrite && !pready_ff;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_ediv     = ediv_ff + 2'h1;
        nxt_eClk     = ediv_ff[1];
        nxt_latched   = latched_ff;
        nxt_settleCnt = settleCnt_ff;
        nxt_mode      = mode_ff;
        // The mode pins are trusted only once their synchronisers have flushed.
        if (!latched_ff) begin
            nxt_settleCnt = settleCnt_ff + 3'h1;
            if (settleCnt_ff == `MODE_SETTLE) begin
                nxt_mode    = pin_ctrl_pkg::op_mode_t'({syn.clean[2], modeAClean_ff});
                nxt_latched = 1'b1;
            end
        end
        nxt_edgeSel  = edgeSel_ff;
        nxt_xMask    = xMask_ff;
        nxt_iMask    = iMask_ff;
        nxt_irv      = irv_ff;
        nxt_hiData   = hiData_ff;
        nxt_muxData  = muxData_ff;
        nxt_muxDir   = muxDir_ff;
        nxt_brq      = brq_ff;
        nxt_brqValid = brqValid_ff;
        nxt_fetchReq = fetchReq_ff;
        nxt_ostb     = 1'b0;
        nxt_irqPrev  = irqPrev_ff;
        nxt_irqPend  = irqPend_ff;
        nxt_strPrev  = strPrev_ff;
        nxt_strEvt   = strEvt_ff;
        nxt_muxIn    = muxIn_ff;
        nxt_prdata   = prdata_ff;
        nxt_pready   = psel && penable && !pready_ff;
        nxt_pslverr  = 1'b0;

        if (eTick) begin
            nxt_irqPrev = irqLvl;
        end
        // A new fetch request wins over the clear of the old one.
        if (eTick && fetchReq_ff) begin
            nxt_fetchReq = 1'b0;
        end
        if (wrEn && paddr == `OFF_CONTROL) begin
            nxt_edgeSel = pwdata[`CTL_EDGE_BIT];
            nxt_xMask   = xMask_ff & pwdata[`CTL_XMASK_BIT];
            nxt_iMask   = pwdata[`CTL_IMASK_BIT];
            nxt_irv     = pwdata[`CTL_IRV_BIT];
            if (pwdata[`CTL_ACK_BIT]) begin
                nxt_irqPend = 1'b0;
            end
            if (pwdata[`CTL_FETCH_BIT]) begin
                nxt_fetchReq = 1'b1;
            end
        end
        if (wrEn && paddr == `OFF_STATUS) begin
            nxt_strEvt = 1'b0;
        end
        if (eTick && edgeSel_ff && irqPrev_ff && !irqLvl) begin
            nxt_irqPend = 1'b1;
        end
        if (strobeLvl && !strPrev_ff && !expanded) begin
            nxt_strEvt = 1'b1;
            nxt_muxIn  = muxed_port_pins_in;
        end
        nxt_strPrev = strobeLvl;
        if (wrEn && paddr == `OFF_HIGH_PORT) begin
            nxt_hiData = pwdata[7:0];
            nxt_ostb   = !expanded;
        end
        if (wrEn && paddr == `OFF_MUX_PORT) begin
            nxt_muxData = pwdata[7:0];
        end
        if (wrEn && paddr == `OFF_MUX_DIR) begin
            nxt_muxDir = pwdata[7:0];
        end
        if (wrEn && paddr == `OFF_BUSREQ && !brqValid_ff) begin
            nxt_brq      = pwdata[25:0];
            nxt_brqValid = 1'b1;
        end
        if (eTick && ph_ff == pin_ctrl_pkg::PH_DATA) begin
            nxt_brqValid = 1'b0;
            if (!brq_ff[`BRQ_WRITE_BIT]) begin
                nxt_muxIn = muxed_port_pins_in;
            end
        end
        if (rdEn) begin
            case (paddr)
                `OFF_CONTROL:   nxt_prdata = {24'h0, 1'b0, 2'h0, 1'b0, irv_ff, iMask_ff,
                                              xMask_ff, edgeSel_ff};
                `OFF_STATUS:    nxt_prdata = {24'h0, mode_ff, irqPend_ff, brqValid_ff,
                                              strEvt_ff, xirqLvl, irqLvl, muxIn_ff[0]};
                `OFF_HIGH_PORT: nxt_prdata = {24'h0, hiData_ff};
                `OFF_MUX_PORT:  nxt_prdata = {24'h0, muxIn_ff};
                `OFF_MUX_DIR:   nxt_prdata = {24'h0, muxDir_ff};
                `OFF_BUSREQ:    nxt_prdata = {6'h0, brq_ff};
                default: begin
                    nxt_prdata  = 32'h0;
                    nxt_pslverr = 1'b1;
                end
            endcase
        end else if (wrEn) begin
            case (paddr)
                `OFF_CONTROL, `OFF_STATUS, `OFF_HIGH_PORT,
                `OFF_MUX_PORT, `OFF_MUX_DIR, `OFF_BUSREQ: nxt_pslverr = 1'b0;
                default: nxt_pslverr = 1'b1;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // External bus sequencer and pin roles.
    always_comb begin
        nxt_ph      = ph_ff;
        nxt_rw      = rw_ff;
        nxt_as      = 1'b0;
        nxt_fetch   = 1'b1;
        nxt_hiOut   = hiOut_ff;
        nxt_muxOut  = muxOut_ff;
        nxt_muxOe   = muxOe_ff;
        if (!expanded) begin
            nxt_hiOut  = hiData_ff;
            nxt_muxOut = muxData_ff;
            nxt_muxOe  = ~muxDir_ff;
            nxt_rw     = 1'b1;
            nxt_ph     = pin_ctrl_pkg::PH_IDLE;
        end else if (eTick) begin
            case (ph_ff)
                pin_ctrl_pkg::PH_IDLE: begin
                    // Direction keeps its last value while idle, so writes keep it low.
                    nxt_muxOe = 8'hFF;
                    if (brqValid_ff) begin
                        nxt_ph     = pin_ctrl_pkg::PH_ADDR;
                        nxt_hiOut  = brq_ff[15:8];
                        nxt_muxOut = brq_ff[7:0];
                        nxt_muxOe  = 8'h00;
                        nxt_as     = 1'b1;
                        nxt_rw     = !brq_ff[`BRQ_WRITE_BIT];
                    end
                end
                pin_ctrl_pkg::PH_ADDR: begin
                    nxt_ph = pin_ctrl_pkg::PH_DATA;
                    if (brq_ff[`BRQ_WRITE_BIT]) begin
                        nxt_muxOut = brq_ff[23:16];
                        nxt_muxOe  = 8'h00;
                    end else if (irv_ff && brq_ff[`BRQ_INT_BIT]) begin
                        nxt_muxOut = brq_ff[23:16];
                        nxt_muxOe  = 8'h00;
                    end else begin
                        nxt_muxOe  = 8'hFF;
                    end
                end
                pin_ctrl_pkg::PH_DATA: begin
                    nxt_ph    = pin_ctrl_pkg::PH_IDLE;
                    nxt_muxOe = 8'hFF;
                end
                default: nxt_ph = pin_ctrl_pkg::PH_IDLE;
            endcase
        end
        if (fetchReq_ff) begin
            nxt_fetch = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_irqReq  = !iMask_ff && (edgeSel_ff ? irqPend_ff : !irqLvl);
        nxt_xirqReq = !xMask_ff && !xirqLvl;
        nxt_strobeB = expanded ? nxt_rw : nxt_ostb;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ediv_ff <= 2'h0; eClk_ff <= 1'b0; latched_ff <= 1'b0;
            settleCnt_ff <= 3'h0;
            strobeB_ff <= 1'b0;
            mode_ff <= pin_ctrl_pkg::MODE_SINGLE;
            edgeSel_ff <= `RST_EDGE_SEL;
            xMask_ff <= `RST_XMASK;
            iMask_ff <= `RST_IMASK; irv_ff <= 1'b0;
            irqPrev_ff <= 1'b1; irqPend_ff <= 1'b0; strPrev_ff <= 1'b0;
            strEvt_ff <= 1'b0; hiData_ff <= 8'h00; muxData_ff <= 8'h00;
            muxDir_ff <= 8'h00; muxIn_ff <= 8'h00; brq_ff <= 26'h0;
            brqValid_ff <= 1'b0; fetchReq_ff <= 1'b0;
            ph_ff <= pin_ctrl_pkg::PH_IDLE; rw_ff <= 1'b1; as_ff <= 1'b0;
            ostb_ff <= 1'b0; fetch_ff <= 1'b1; hiOut_ff <= 8'h00;
            muxOut_ff <= 8'h00; muxOe_ff <= 8'hFF; irqReq_ff <= 1'b0;
            xirqReq_ff <= 1'b0; prdata_ff <= 32'h0; pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            ediv_ff <= nxt_ediv; eClk_ff <= nxt_eClk; latched_ff <= nxt_latched;
            settleCnt_ff <= nxt_settleCnt;
            strobeB_ff <= nxt_strobeB;
            mode_ff <= nxt_mode; edgeSel_ff <= nxt_edgeSel; xMask_ff <= nxt_xMask;
            iMask_ff <= nxt_iMask; irv_ff <= nxt_irv; irqPrev_ff <= nxt_irqPrev;
            irqPend_ff <= nxt_irqPend; strPrev_ff <= nxt_strPrev;
            strEvt_ff <= nxt_strEvt; hiData_ff <= nxt_hiData;
            muxData_ff <= nxt_muxData; muxDir_ff <= nxt_muxDir;
            muxIn_ff <= nxt_muxIn; brq_ff <= nxt_brq; brqValid_ff <= nxt_brqValid;
            fetchReq_ff <= nxt_fetchReq; ph_ff <= nxt_ph; rw_ff <= nxt_rw;
            as_ff <= nxt_as; ostb_ff <= nxt_ostb; fetch_ff <= nxt_fetch;
            hiOut_ff <= nxt_hiOut; muxOut_ff <= nxt_muxOut; muxOe_ff <= nxt_muxOe;
            irqReq_ff <= nxt_irqReq; xirqReq_ff <= nxt_xirqReq;
            prdata_ff <= nxt_prdata; pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // In expanded modes the strobe-B pin carries the bus direction.
    assign address_latch_strobe     = as_ff;
    assign output_strobe            = strobeB_ff;
    assign opcode_fetch_indicator_n = 1'b0;
    assign fetchIndOe_n             = fetch_ff;
    assign eClk                     = eClk_ff;
    assign irqReq                   = irqReq_ff;
    assign xirqReq                  = xirqReq_ff;
    assign high_port_pins           = hiOut_ff;
    assign muxed_port_pins_out      = muxOut_ff;
    assign muxedPortOe_n            = muxOe_ff;
    assign prdata                   = prdata_ff;
    assign pready                   = pready_ff;
    assign pslverr                  = pslverr_ff;

    ////////////////////////////////////////////////////////////////////////////
    a_reset_level: assert property (@(posedge clk_sys) $fell(rst) |-> !edgeSel_ff)
        else $error("edge select not cleared by reset");
    a_xmask_reset: assert property (@(posedge clk_sys) $fell(rst) |-> xMask_ff)
        else $error("xmask not set by reset");
    a_nonmaskable_request_n_level: assert property (@(posedge clk_sys) disable iff (rst)
        (!xMask_ff && !xirqLvl) |=> xirqReq)
        else $error("level nonmaskable_request_n not requested");
    a_mode_fixed: assert property (@(posedge clk_sys) disable iff (rst)
        latched_ff |=> $stable(mode_ff))
        else $error("mode changed after reset");
    a_edge_latch: assert property (@(posedge clk_sys) disable iff (rst)
        (eTick && edgeSel_ff && irqPrev_ff && !irqLvl) |=> irqPend_ff)
        else $error("falling edge lost");
    a_level_again: assert property (@(posedge clk_sys) disable iff (rst)
        (!edgeSel_ff && !iMask_ff && !irqLvl) |=> irqReq)
        else $error("held line not requested");
    a_dir_write: assert property (@(posedge clk_sys) disable iff (rst)
        (expanded && ph_ff == pin_ctrl_pkg::PH_DATA && brq_ff[`BRQ_WRITE_BIT])
        |-> !output_strobe)
        else $error("direction high during write");
    a_high_single: assert property (@(posedge clk_sys) disable iff (rst)
        (!expanded && latched_ff) |=> ##1 (high_port_pins == $past(hiData_ff)))
        else $error("high port not general output");
    c_edge_mode: cover property (@(posedge clk_sys) disable iff (rst) irqPend_ff);
    c_ext_write: cover property (@(posedge clk_sys) disable iff (rst) as_ff && !rw_ff);
    c_nonmaskable_request_n: cover property (@(posedge clk_sys) disable iff (rst) xirqReq);
endmodule
`default_nettype wire

// >>> tb/pin_partner.sv
`timescale 1ns/100ps
`default_nettype none
module pin_partner (
    // Clock.
    input  wire logic       clk_sys,
    // Bench controls.
    input  wire logic [1:0] irqPull,
    input  wire logic       xPull,
    input  wire logic       expd,
    input  wire logic [7:0] portVal,
    // Device pins.
    input  wire logic       ale,
    input  wire logic       rdWr,
    input  wire logic [7:0] pOut,
    input  wire logic [7:0] pOe_n,
    output logic            irqLine_n,
    output logic            xLine_n,
    output logic      [7:0] pIn
);
    logic [7:0] addrLo = 8'h00;
    // Open-drain sources on pulled-up lines; a source holds until the bench clears its pull.
    assign irqLine_n = ~|irqPull;
    assign xLine_n   = ~xPull;
    always @(posedge clk_sys) if (ale) addrLo <= pOut;
    assign pIn = (~pOe_n & pOut) | (pOe_n & ((expd && rdWr) ? ~addrLo : portVal));
endmodule
`default_nettype wire

// >>> tb/mode_pin_and_interrupt_interface_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "pin_ctrl_cfg.svh"
module mode_pin_and_interrupt_interface_bench;
    logic        clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, v, seed = 32'h695B;
    logic        pready, pslverr, pe, irqN, xN, modeA = 1'b1, modeB = 1'b0, stb = 1'b0;
    logic        fetchN, fetchOe_n, ale, ostb, eClk, irqReq, xirqReq, expd = 1'b0;
    logic        xPull = 1'b0, watch = 1'b0, lastStb = 1'b0;
    logic [1:0]  irqPull = 2'b00;
    logic [7:0]  hp, mOut, mOe_n, mIn, portVal = 8'h00;
    logic [2:0]  ec;
    int          fails = 0, num_checks = 0, cyc = 0, chgCnt = 0, highCnt = 0, n;
    logic [15:0] expAddr[$];

    pin_ctrl i_pin_ctrl (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irqPin_n(irqN), .nonmaskable_request_n(xN),
        .mode_select_a(modeA), .mode_select_b(modeB), .opcode_fetch_indicator_n(fetchN),
        .fetchIndOe_n(fetchOe_n), .input_strobe(stb), .address_latch_strobe(ale),
        .output_strobe(ostb), .eClk(eClk), .irqReq(irqReq), .xirqReq(xirqReq),
        .high_port_pins(hp), .muxed_port_pins_in(mIn), .muxed_port_pins_out(mOut),
        .muxedPortOe_n(mOe_n));
    pin_partner i_pin_partner (.clk_sys(clk_sys), .irqPull(irqPull), .xPull(xPull),
        .expd(expd), .portVal(portVal), .ale(ale), .rdWr(ostb), .pOut(mOut),
        .pOe_n(mOe_n), .irqLine_n(irqN), .xLine_n(xN), .pIn(mIn));

    always #20 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////////
    task automatic results();
        if (fails == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // The answer is looked at mid-cycle; only the bench timeout ends this wait.
        do @(negedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        pe = pslverr;
        @(posedge clk_sys);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic doReset(input logic a, input logic b);
        @(posedge clk_sys);
        rst <= 1'b1;
        modeA <= a;
        modeB <= b;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask
    task automatic settle();
        repeat (10) @(posedge clk_sys);
    endtask
    task automatic waitAle();
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (ale !== 1'b1 && n < 40);
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (ostb !== lastStb) chgCnt++;
        lastStb = ostb;
        if (watch && ostb === 1'b1) highCnt++;
        if (cyc == 20000) begin
            fails++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        doReset(1'b1, 1'b0);
        apb(1'b0, `OFF_CONTROL, 32'h0);
        chk(32'(rd[2:0]), 32'h6);
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk(32'(rd[7:6]), 32'(pin_ctrl_pkg::MODE_SINGLE));
        xPull <= 1'b1;
        settle();
        chk(32'(xirqReq), 32'h0);
        apb(1'b1, `OFF_CONTROL, 32'h4);
        settle();
        chk(32'(xirqReq), 32'h1);
        xPull <= 1'b0;
        settle();
        chk(32'(xirqReq), 32'h0);
        irqPull <= 2'b11;
        apb(1'b1, `OFF_CONTROL, 32'h0);
        settle();
        chk(32'(irqReq), 32'h1);
        apb(1'b1, `OFF_CONTROL, 32'h4);
        settle();
        chk(32'(irqReq), 32'h0);
        irqPull <= 2'b01;
        apb(1'b1, `OFF_CONTROL, 32'h0);
        settle();
        chk(32'(irqReq), 32'h1);
        irqPull <= 2'b00;
        settle();
        chk(32'(irqReq), 32'h0);
        apb(1'b1, `OFF_CONTROL, 32'h1);
        irqPull <= 2'b10;
        repeat (12) @(posedge clk_sys);
        irqPull <= 2'b00;
        settle();
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk(32'(rd[5]), 32'h1);
        chk(32'(irqReq), 32'h1);
        apb(1'b1, `OFF_CONTROL, 32'h11);
        settle();
        chk(32'(irqReq), 32'h0);
        chgCnt = 0;
        for (int i = 0; i < 3; i++) begin
            v = rnd();
            apb(1'b1, `OFF_HIGH_PORT, v);
            settle();
            chk(32'(hp), 32'(v[7:0]));
        end
        chk(chgCnt, 32'h6);
        apb(1'b1, `OFF_MUX_DIR, 32'h0);
        portVal <= rnd();
        stb <= 1'b1;
        settle();
        stb <= 1'b0;
        settle();
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk(32'(rd[3]), 32'h1);
        apb(1'b0, `OFF_MUX_PORT, 32'h0);
        chk(32'(rd[7:0]), 32'(portVal));
        v = rnd();
        apb(1'b1, `OFF_MUX_DIR, 32'hFF);
        apb(1'b1, `OFF_MUX_PORT, v);
        settle();
        chk({mOe_n, mOut}, {8'h00, v[7:0]});
        apb(1'b0, 12'h0FC, 32'h0);
        chk({31'h0, pe}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, `OFF_CONTROL, 32'h80);
        for (n = 0; n < 20 && fetchOe_n !== 1'b0; n++) @(negedge clk_sys);
        chk({fetchOe_n, fetchN}, 32'h0);
        @(negedge clk_sys) ec[0] = eClk;
        repeat (2) @(negedge clk_sys);
        ec[1] = eClk;
        repeat (2) @(negedge clk_sys);
        ec[2] = eClk;
        chk(32'(ec), {29'h0, ec[0], ~ec[0], ec[0]});
        doReset(1'b1, 1'b1);
        expd <= 1'b1;
        modeA <= 1'b0;
        settle();
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk(32'(rd[7:6]), 32'(pin_ctrl_pkg::MODE_EXPAND));
        highCnt = 0;
        for (int i = 0; i < 3; i++) begin
            v = rnd();
            expAddr.push_back(v[15:0]);
            apb(1'b1, `OFF_BUSREQ, {7'h0, i < 2, v[23:0]});
            waitAle();
            watch = (i == 0);
            chk({hp, mOut}, 32'(expAddr.pop_front()));
            chk(32'(ostb), (i < 2) ? 32'h0 : 32'h1);
            do apb(1'b0, `OFF_STATUS, 32'h0); while (rd[4] === 1'b1 && cyc < 19000);
        end
        apb(1'b0, `OFF_MUX_PORT, 32'h0);
        chk(32'(rd[7:0]), {24'h0, ~v[7:0]});
        chk(highCnt, 32'h0);
        apb(1'b1, `OFF_CONTROL, 32'h8);
        v = rnd();
        apb(1'b1, `OFF_BUSREQ, {6'h0, 2'b10, v[23:0]});
        waitAle();
        repeat (4) @(negedge clk_sys);
        chk({ostb, mOe_n, mOut}, {15'h0, 1'b1, 8'h00, v[23:16]});
        doReset(1'b0, 1'b1);
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk(32'(rd[7:6]), 32'(pin_ctrl_pkg::MODE_TEST));
        doReset(1'b0, 1'b0);
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk(32'(rd[7:6]), 32'(pin_ctrl_pkg::MODE_BOOT));
        results();
    end
endmodule
`default_nettype wire
